// *** block_ram_cfg.svh ***
// Register offsets, reset values and sizes of the block memory.
`ifndef BLOCK_RAM_CFG_SVH
`define BLOCK_RAM_CFG_SVH
`define OFS_CTRL          12'h000
`define OFS_FULL_THR      12'h004
`define OFS_NFULL_THR     12'h008
`define OFS_NEMPTY_THR    12'h00c
`define OFS_STATUS        12'h010
`define OFS_PRELOAD       12'h014
`define CTRL_RST          13'h0360
`define FULL_RST          14'h03ff
`define NFULL_RST         14'h0300
`define NEMPTY_RST        14'h0080
`define FLAGS_RST         4'h3
`define ARRAY_BITS        9216
`define DATA_W            18
`define PRELOAD_DATA_LSB  14
`define ONE14             14'h0001
`endif

// *** block_ram_pkg.sv ***
// Types shared by the block memory design.
package block_ram_pkg;
	typedef enum logic [1:0] {
		MODE_SINGLE = 2'b00,
		MODE_DUAL   = 2'b01,
		MODE_PSEUDO = 2'b10,
		MODE_FIFO   = 2'b11
	} mem_mode_t;
	typedef enum logic [1:0] {
		WB_NORMAL  = 2'b00,
		WB_THROUGH = 2'b01,
		WB_OLD     = 2'b10,
		WB_SPARE   = 2'b11
	} wr_behav_t;
	typedef struct packed {
		mem_mode_t  mode;
		logic [2:0] wid_a;
		logic [2:0] wid_b;
		wr_behav_t  behav;
		logic       outreg;
		logic       async_clr;
		logic       rom;
	} cfg_t;
	typedef struct packed {
		logic        sel;
		logic        sel_alt;
		logic        clk_gate;
		logic        we;
		logic        outreg_clk_gate;
		logic        clear;
		logic [12:0] addr;
		logic [17:0] wdata;
	} port_req_t;
	typedef struct packed {
		logic [13:0] full;
		logic [13:0] nfull;
		logic [13:0] nempty;
	} thr_t;
	typedef struct packed {
		logic full_flag;
		logic nearly_full_flag;
		logic nearly_empty_flag;
		logic empty_flag;
	} fifo_flags_t;
	typedef struct packed {
		logic        load;
		logic        wr;
		logic [17:0] wdata;
		logic [17:0] old;
	} stage_in_t;
endpackage

// *** port_out_stage.sv ***
// Output latch and optional output register of one memory port.
`timescale 1ns/10ps
module port_out_stage
	import block_ram_pkg::*;
(
	// Clock and resets.
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       sync_clr,
	// Access result and options.
	input  wire stage_in_t  acc,
	input  wire wr_behav_t  behav,
	input  wire logic       outreg,
	input  wire logic       outreg_clk_gate,
	// Port read data.
	output logic [17:0]     dout
);
	typedef struct packed {
		logic [17:0] latch;
		logic [17:0] dout;
	} stage_t;
	stage_t s_q;
	stage_t s_d;

	// Latch update per write behaviour, then the bypass or output register.
	always_comb begin
		s_d = s_q;
		if (sync_clr) begin
			s_d = '0;
		end else begin
			if (acc.load && !acc.wr) begin
				s_d.latch = acc.old;
			end else if (acc.load) begin
				unique case (behav)
					WB_THROUGH: s_d.latch = acc.wdata;
					WB_OLD:     s_d.latch = acc.old;
					WB_NORMAL,
					WB_SPARE:   s_d.latch = s_q.latch;
				endcase
			end
			if (!outreg) s_d.dout = s_d.latch;
			else if (outreg_clk_gate) s_d.dout = s_q.latch;
		end
	end

	// State register, cleared by the port or chip-wide reset.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) s_q <= '0;
		else s_q <= s_d;
	end

	assign dout = s_q.dout;

	property p_normal_hold;
		@(posedge clk) disable iff (!arst_n)
		acc.load && acc.wr && behav == WB_NORMAL && !sync_clr |=> $stable(s_q.latch);
	endproperty
	a_normal_hold: assert property (p_normal_hold)
		else $error("normal write changed the output latch");
	property p_through;
		@(posedge clk) disable iff (!arst_n)
		acc.load && acc.wr && behav == WB_THROUGH && !sync_clr
			|=> s_q.latch == $past(acc.wdata);
	endproperty
	a_through: assert property (p_through)
		else $error("write-through data missing on output");
	property p_old;
		@(posedge clk) disable iff (!arst_n)
		acc.load && acc.wr && behav == WB_OLD && !sync_clr |=> s_q.latch == $past(acc.old);
	endproperty
	a_old: assert property (p_old)
		else $error("old contents missing on output");
	property p_sync_clear;
		@(posedge clk) disable iff (!arst_n)
		sync_clr |=> s_q.latch == '0 && dout == '0;
	endproperty
	a_sync_clear: assert property (p_sync_clear)
		else $error("synchronous clear did not clear the port");
	property p_outreg;
		@(posedge clk) disable iff (!arst_n)
		outreg && outreg_clk_gate && !sync_clr |=> dout == $past(s_q.latch);
	endproperty
	a_outreg: assert property (p_outreg)
		else $error("output register did not take the latch");
endmodule

// *** block_ram_fifo.sv ***
// Block memory with RAM, ROM and FIFO modes and an APB control port.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "block_ram_cfg.svh"

module block_ram_fifo
	import block_ram_pkg::*;
(
	// APB slave.
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Memory ports from fabric logic.
	input  wire port_req_t   port_a_req,
	input  wire port_req_t   port_b_req,
	output logic [17:0]      port_a_rdata,
	output logic [17:0]      port_b_rdata,
	// Reset inputs.
	input  wire logic        global_set_reset_n,
	input  wire logic        fifo_global_reset,
	input  wire logic        rd_ptr_rewind,
	// FIFO flags.
	output fifo_flags_t      fifo_flags
);
	typedef struct packed {
		cfg_t        cfg;
		thr_t        thr;
		port_req_t   ra;
		port_req_t   rb;
		logic        pready;
		logic [31:0] prdata;
		logic        pslverr;
	} state_t;
	typedef struct packed {
		logic [13:0] wr_ptr;
		logic        wr_ph;
		fifo_flags_t flags;
	} wside_t;
	typedef struct packed {
		logic [13:0] rd_ptr;
		logic        rd_ph;
	} rside_t;

	state_t      st_q;
	state_t      st_d;
	wside_t      ws_q;
	wside_t      ws_d;
	rside_t      rs_q;
	rside_t      rs_d;
	logic        mem [0:`ARRAY_BITS-1];
	logic        fifo_clr_n;
	logic        rd_clr_n;
	logic        arst_a_n;
	logic        arst_b_n;
	logic        is_fifo;
	logic        shape_err;
	logic        access;
	logic        commit;
	logic        bad;
	logic        pl_wr;
	logic        sel_a;
	logic        sel_b;
	logic        push;
	logic        pop;
	logic        wen_a;
	logic        wen_b;
	logic        wr_a_any;
	logic [2:0]  code_b;
	logic [4:0]  bits_a;
	logic [4:0]  bits_b;
	logic [13:0] depth_a;
	logic [13:0] cnt;
	logic [13:0] cnt_nx;
	logic [13:0] base_a;
	logic [13:0] base_b;
	logic [13:0] base_wa;
	logic [17:0] data_wa;
	logic [17:0] old_a;
	logic [17:0] old_b;
	stage_in_t   acc_a;
	stage_in_t   acc_b;

	// Word width of a shape code; codes above four are illegal.
	function automatic logic [4:0] width_of(input logic [2:0] c);
		unique case (c)
			3'h0: return 5'h01;
			3'h1: return 5'h02;
			3'h2: return 5'h04;
			3'h3: return 5'h09;
			default: return 5'h12;
		endcase
	endfunction

	// Word count of a shape code.
	function automatic logic [13:0] depth_of(input logic [2:0] c);
		unique case (c)
			3'h0: return 14'h2000;
			3'h1: return 14'h1000;
			3'h2: return 14'h0800;
			3'h3: return 14'h0400;
			default: return 14'h0200;
		endcase
	endfunction

	// First storage bit of a word; every width packs from bit zero upward.
	function automatic logic [13:0] bit_base(input logic [13:0] w, input logic [2:0] c);
		return 14'((w & (depth_of(c) - `ONE14)) * 14'(width_of(c)));
	endfunction

	// Words held, from pointers that carry a wrap phase.
	function automatic logic [13:0] fifo_count(input logic [13:0] w, input logic wp,
		input logic [13:0] r, input logic rp, input logic [13:0] d);
		return (wp == rp) ? 14'(w - r) : 14'(d - r + w);
	endfunction

	// Pointer advance with wrap at the depth, toggling the phase.
	function automatic logic [14:0] ptr_next(input logic [13:0] p, input logic ph,
		input logic [13:0] d);
		return (p == d - `ONE14) ? {~ph, 14'h0000} : {ph, 14'(p + `ONE14)};
	endfunction

	function automatic logic in_range(input logic [13:0] v, input logic [13:0] lo,
		input logic [13:0] hi);
		return v >= lo && v <= hi;
	endfunction

	// Reset nets: FIFO reset and rewind act without the clock.
	assign fifo_clr_n = presetn & ~fifo_global_reset;
	assign rd_clr_n   = fifo_clr_n & ~rd_ptr_rewind;
	assign arst_a_n   = presetn & global_set_reset_n
		& ~(port_a_req.clear & st_q.cfg.async_clr);
	assign arst_b_n   = presetn & global_set_reset_n
		& ~(port_b_req.clear & st_q.cfg.async_clr);

	// APB phases and the register error check.
	assign access = psel && penable && !st_q.pready;
	assign commit = psel && penable && st_q.pready;
	always_comb begin
		bad = !(paddr inside {`OFS_CTRL, `OFS_FULL_THR, `OFS_NFULL_THR, `OFS_NEMPTY_THR,
			`OFS_STATUS, `OFS_PRELOAD});
		if (pwrite && paddr == `OFS_FULL_THR)
			bad = !in_range(pwdata[13:0], `ONE14, depth_a - `ONE14);
		if (pwrite && (paddr == `OFS_NFULL_THR || paddr == `OFS_NEMPTY_THR))
			bad = !in_range(pwdata[13:0], `ONE14, st_q.thr.full - `ONE14);
	end
	assign pl_wr = commit && pwrite && paddr == `OFS_PRELOAD;

	// Mode, shape and port selection.
	assign is_fifo   = st_q.cfg.mode == MODE_FIFO;
	assign shape_err = st_q.cfg.wid_a > 3'h4 || st_q.cfg.wid_b > 3'h4
		|| (st_q.cfg.mode inside {MODE_SINGLE, MODE_DUAL}
		&& (st_q.cfg.wid_a == 3'h4 || st_q.cfg.wid_b == 3'h4));
	assign code_b  = is_fifo ? st_q.cfg.wid_a : st_q.cfg.wid_b;
	assign bits_a  = width_of(st_q.cfg.wid_a);
	assign bits_b  = width_of(code_b);
	assign depth_a = depth_of(st_q.cfg.wid_a);
	assign sel_a = st_q.ra.sel && st_q.ra.clk_gate && !shape_err
		&& (!is_fifo || st_q.ra.sel_alt);
	assign sel_b = st_q.rb.sel && st_q.rb.clk_gate && !shape_err
		&& st_q.cfg.mode != MODE_SINGLE && (!is_fifo || st_q.rb.sel_alt);

	// FIFO strobes: writes when full and pops when empty are dropped.
	assign cnt  = fifo_count(ws_q.wr_ptr, ws_q.wr_ph, rs_q.rd_ptr, rs_q.rd_ph, depth_a);
	assign push = is_fifo && sel_a && st_q.ra.we && cnt < st_q.thr.full && !pl_wr;
	assign pop  = is_fifo && sel_b && st_q.rb.we && cnt != 14'h0000;

	// RAM writes; pseudo dual port writes on port A only.
	assign wen_a = !is_fifo && sel_a && st_q.ra.we && !st_q.cfg.rom && !pl_wr;
	assign wen_b = st_q.cfg.mode == MODE_DUAL && sel_b && st_q.rb.we
		&& !st_q.cfg.rom;
	assign base_a = is_fifo ? bit_base(ws_q.wr_ptr, st_q.cfg.wid_a)
		: bit_base({1'b0, st_q.ra.addr}, st_q.cfg.wid_a);
	assign base_b = is_fifo ? bit_base(rs_q.rd_ptr, code_b)
		: bit_base({1'b0, st_q.rb.addr}, code_b);

	// Port A array slot, taken by a preload when software writes one.
	assign wr_a_any = wen_a || push || pl_wr;
	assign base_wa  = pl_wr ? bit_base(pwdata[13:0], st_q.cfg.wid_a) : base_a;
	assign data_wa  = pl_wr ? pwdata[31:`PRELOAD_DATA_LSB] : st_q.ra.wdata;

	// Array read of the addressed words before any write at this edge.
	always_comb begin
		old_a = '0;
		old_b = '0;
		for (int i = 0; i < `DATA_W; i++) begin
			if (i < int'(bits_a)) old_a[i] = mem[14'(base_a + 14'(i))];
			if (i < int'(bits_b)) old_b[i] = mem[14'(base_b + 14'(i))];
		end
	end

	// Array write; port A follows port B at each bit index, so it wins a collision unless port B reaches the bit at a higher index.
	always_ff @(posedge pclk) begin
		for (int i = 0; i < `DATA_W; i++) begin
			if (wen_b && i < int'(bits_b))
				mem[14'(base_b + 14'(i))] <= st_q.rb.wdata[i];
			if (wr_a_any && i < int'(bits_a))
				mem[14'(base_wa + 14'(i))] <= data_wa[i];
		end
	end

	// Access results handed to the port output stages.
	always_comb begin
		acc_a.load  = sel_a && !is_fifo && !pl_wr;
		acc_a.wr    = wen_a;
		acc_a.wdata = st_q.ra.wdata;
		acc_a.old   = old_a;
		acc_b.load  = (sel_b && !is_fifo) || pop;
		acc_b.wr    = wen_b;
		acc_b.wdata = st_q.rb.wdata;
		acc_b.old   = old_b;
	end

	// Register file, APB answer and input registers of both ports.
	always_comb begin
		st_d         = st_q;
		st_d.ra      = port_a_req;
		st_d.rb      = port_b_req;
		st_d.pready  = access;
		st_d.pslverr = access && bad;
		st_d.prdata  = '0;
		if (access && !pwrite && !bad) begin
			if (paddr == `OFS_CTRL) st_d.prdata = 32'(st_q.cfg);
			if (paddr == `OFS_FULL_THR) st_d.prdata = 32'(st_q.thr.full);
			if (paddr == `OFS_NFULL_THR) st_d.prdata = 32'(st_q.thr.nfull);
			if (paddr == `OFS_NEMPTY_THR) st_d.prdata = 32'(st_q.thr.nempty);
			if (paddr == `OFS_STATUS) st_d.prdata = {13'h0000, shape_err, ws_q.flags, cnt};
		end
		if (commit && pwrite && !bad) begin
			if (paddr == `OFS_CTRL) st_d.cfg = cfg_t'(pwdata[12:0]);
			if (paddr == `OFS_FULL_THR) st_d.thr.full = pwdata[13:0];
			if (paddr == `OFS_NFULL_THR) st_d.thr.nfull = pwdata[13:0];
			if (paddr == `OFS_NEMPTY_THR) st_d.thr.nempty = pwdata[13:0];
		end
	end

	// Read side pointer.
	always_comb begin
		rs_d = rs_q;
		if (pop) {rs_d.rd_ph, rs_d.rd_ptr} = ptr_next(rs_q.rd_ptr, rs_q.rd_ph, depth_a);
	end

	// Write side pointer and the four flags, registered from the new count.
	assign cnt_nx = fifo_count(ws_d.wr_ptr, ws_d.wr_ph, rs_d.rd_ptr, rs_d.rd_ph, depth_a);
	always_comb begin
		ws_d = ws_q;
		if (push) {ws_d.wr_ph, ws_d.wr_ptr} = ptr_next(ws_q.wr_ptr, ws_q.wr_ph, depth_a);
		ws_d.flags.full_flag         = cnt_nx >= st_q.thr.full;
		ws_d.flags.nearly_full_flag  = cnt_nx >= st_q.thr.nfull;
		ws_d.flags.nearly_empty_flag = cnt_nx <= st_q.thr.nempty;
		ws_d.flags.empty_flag        = cnt_nx == 14'h0000;
	end

	// Control state register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q     <= '0;
			st_q.cfg <= cfg_t'(`CTRL_RST);
			st_q.thr <= {`FULL_RST, `NFULL_RST, `NEMPTY_RST};
		end else begin
			st_q <= st_d;
		end
	end

	// Write pointer and flags, cleared by the FIFO global reset.
	always_ff @(posedge pclk or negedge fifo_clr_n) begin
		if (!fifo_clr_n) begin
			ws_q       <= '0;
			ws_q.flags <= `FLAGS_RST;
		end else begin
			ws_q <= ws_d;
		end
	end

	// Read pointer, also cleared alone by the rewind.
	always_ff @(posedge pclk or negedge rd_clr_n) begin
		if (!rd_clr_n) rs_q <= '0;
		else rs_q <= rs_d;
	end

	// Port output stages; clears act per port, the chip-wide reset on both.
	port_out_stage u_out_a (
		.clk             (pclk),
		.arst_n          (arst_a_n),
		.sync_clr        (port_a_req.clear && !st_q.cfg.async_clr),
		.acc             (acc_a),
		.behav           (st_q.cfg.behav),
		.outreg          (st_q.cfg.outreg),
		.outreg_clk_gate (st_q.ra.outreg_clk_gate),
		.dout            (port_a_rdata)
	);
	port_out_stage u_out_b (
		.clk             (pclk),
		.arst_n          (arst_b_n),
		.sync_clr        (port_b_req.clear && !st_q.cfg.async_clr),
		.acc             (acc_b),
		.behav           (st_q.cfg.behav),
		.outreg          (st_q.cfg.outreg),
		.outreg_clk_gate (st_q.rb.outreg_clk_gate),
		.dout            (port_b_rdata)
	);

	assign prdata     = st_q.prdata;
	assign pready     = st_q.pready;
	assign pslverr    = st_q.pslverr;
	assign fifo_flags = ws_q.flags;

	property p_rom_no_write;
		@(posedge pclk) disable iff (!presetn)
		st_q.cfg.rom && !pl_wr |-> !wen_a && !wen_b && !push;
	endproperty
	a_rom_no_write: assert property (p_rom_no_write)
		else $error("port write reached the array in rom mode");
	property p_full_ignored;
		@(posedge pclk) disable iff (!fifo_clr_n)
		is_fifo && cnt >= st_q.thr.full |=> $stable(ws_q.wr_ptr) && $stable(ws_q.wr_ph);
	endproperty
	a_full_ignored: assert property (p_full_ignored)
		else $error("write accepted while full");
	property p_push_step;
		@(posedge pclk) disable iff (!fifo_clr_n)
		push |=> ws_q.wr_ph != $past(ws_q.wr_ph) || ws_q.wr_ptr == $past(ws_q.wr_ptr) + `ONE14;
	endproperty
	a_push_step: assert property (p_push_step)
		else $error("write pointer did not advance on a push");
	property p_empty_flag;
		@(posedge pclk) disable iff (!rd_clr_n)
		$past(rd_clr_n) && $stable(st_q.cfg) |-> ws_q.flags.empty_flag == (cnt == 14'h0000);
	endproperty
	a_empty_flag: assert property (p_empty_flag)
		else $error("empty flag disagrees with the count");
	property p_full_flag;
		@(posedge pclk) disable iff (!rd_clr_n)
		$past(rd_clr_n) && $stable(st_q.thr) && $stable(st_q.cfg)
			|-> ws_q.flags.full_flag == (cnt >= st_q.thr.full);
	endproperty
	a_full_flag: assert property (p_full_flag)
		else $error("full flag disagrees with the count");
	property p_rewind;
		@(posedge pclk) disable iff (!fifo_clr_n)
		rd_ptr_rewind |-> rs_q.rd_ptr == 14'h0000 && !rs_q.rd_ph;
	endproperty
	a_rewind: assert property (p_rewind)
		else $error("rewind did not clear the read pointer");
	property p_global_reset;
		@(posedge pclk) disable iff (!presetn)
		fifo_global_reset |-> ws_q.wr_ptr == 14'h0000 && rs_q.rd_ptr == 14'h0000
			&& fifo_flags == `FLAGS_RST;
	endproperty
	a_global_reset: assert property (p_global_reset)
		else $error("global reset left pointers or flags set");
	property p_chip_reset;
		@(posedge pclk) disable iff (!presetn)
		!global_set_reset_n |-> port_a_rdata == '0 && port_b_rdata == '0;
	endproperty
	a_chip_reset: assert property (p_chip_reset)
		else $error("chip-wide reset did not clear port outputs");
endmodule

// *** fabric_model.sv ***
// Fabric-side driver model for the two memory ports.
`timescale 1ns/10ps
module fabric_model
	import block_ram_pkg::*;
(
	// Clock.
	input  wire logic pclk,
	// Port requests towards the memory.
	output port_req_t port_a_req,
	output port_req_t port_b_req
);
	// Released address and data lines show inverted values and all other lines go low, so a stale copy never looks valid.
	function automatic port_req_t idle(input port_req_t r);
		idle = '0;
		idle.addr = ~r.addr;
		idle.wdata = ~r.wdata;
	endfunction

	// Both ports start with every gate and strobe low.
	initial begin
		port_a_req = '0;
		port_b_req = '0;
	end

	// One access on port A or B, held for one edge, then gates drop again.
	task automatic go(input logic b, input logic [1:0] s, input logic w, input logic c,
		input logic [12:0] ad, input logic [17:0] d);
		port_req_t r;
		r = '{sel: s[1], sel_alt: s[0], clk_gate: 1'h1, we: w, outreg_clk_gate: 1'h1,
			clear: c, addr: ad, wdata: d};
		@(posedge pclk);
		if (b) port_b_req <= r;
		else port_a_req <= r;
		@(posedge pclk);
		if (b) port_b_req <= idle(r);
		else port_a_req <= idle(r);
	endtask
endmodule

// *** tb.sv ***
// Self-checking testbench for the block memory.
`timescale 1ns/10ps
`include "block_ram_cfg.svh"
module tb
	import block_ram_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ev;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rv;
	logic        global_set_reset_n, fifo_global_reset, rd_ptr_rewind;
	port_req_t   port_a_req, port_b_req;
	logic [17:0] port_a_rdata, port_b_rdata;
	fifo_flags_t fifo_flags;
	int          n_mismatch = 0;
	int          compares = 0;

	block_ram_fifo uut(.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .port_a_req, .port_b_req, .port_a_rdata,
		.port_b_rdata, .global_set_reset_n, .fifo_global_reset, .rd_ptr_rewind,
		.fifo_flags);
	fabric_model fab(.pclk, .port_a_req, .port_b_req);

	// Free-running 125 MHz clock.
	initial begin
		pclk = 1'h0;
		forever #4 pclk = ~pclk;
	end

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD t=%0t got %h expected %h", $time, g, e);
		end
	endtask

	// Lets the next edge land, then samples settled outputs.
	task automatic tick;
		@(posedge pclk);
		#1;
	endtask

	// One APB transfer; the request holds until pready is seen at a rising edge.
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		// The answer is looked at once settled; it stands through the next rising edge.
		@(posedge pclk);
		#1;
		while (pready !== 1'h1 && n < 50) begin
			@(posedge pclk);
			#1;
			n++;
		end
		if (n == 50) n_mismatch++;
		rv = prdata;
		ev = pslverr;
		@(posedge pclk);
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	// Register write with the expected error answer.
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
		apb(1'h1, a, d);
		chk(32'(ev), 32'(e));
	endtask

	// Register read with the expected value.
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		chk(rv, x);
		chk(32'(ev), 32'h0);
	endtask

	// Port access and output check.
	task automatic acc(input logic b, input logic [1:0] s, input logic w,
		input logic [12:0] ad, input logic [17:0] d);
		fab.go(b, s, w, 1'h0, ad, d);
	endtask
	task automatic look(input logic b, input logic [17:0] x);
		tick();
		chk(32'(b ? port_b_rdata : port_a_rdata), 32'(x));
	endtask

	// Pulses the FIFO global reset or the rewind while all strobes are low.
	task automatic rst_pulse(input logic rw);
		@(posedge pclk);
		if (rw) rd_ptr_rewind <= 1'h1;
		else fifo_global_reset <= 1'h1;
		@(posedge pclk);
		rd_ptr_rewind <= 1'h0;
		fifo_global_reset <= 1'h0;
	endtask

	// Reset values, a bad shape and an unmapped place.
	task automatic t_regs;
		rd(`OFS_CTRL, 32'h00000360);
		rd(`OFS_FULL_THR, 32'h000003ff);
		rd(`OFS_NFULL_THR, 32'h00000300);
		rd(`OFS_NEMPTY_THR, 32'h00000080);
		rd(`OFS_STATUS, 32'h0000c000);
		wr(`OFS_CTRL, 32'h00000400, 1'h0);
		rd(`OFS_STATUS, 32'h0004c000);
		wr(12'h018, 32'h00000001, 1'h1);
		rd(`OFS_PRELOAD, 32'h0);
		$display("test regs done");
	endtask

	// The three write behaviours and a deselected write.
	task automatic t_ram;
		wr(`OFS_CTRL, 32'h00000360, 1'h0);
		acc(1'h0, 2'h3, 1'h1, 13'h5, 18'h1a5);
		acc(1'h0, 2'h3, 1'h0, 13'h5, 18'h0);
		look(1'h0, 18'h1a5);
		acc(1'h0, 2'h3, 1'h1, 13'h5, 18'h055);
		look(1'h0, 18'h1a5);
		wr(`OFS_CTRL, 32'h00000368, 1'h0);
		acc(1'h0, 2'h3, 1'h1, 13'h5, 18'h0c3);
		look(1'h0, 18'h0c3);
		wr(`OFS_CTRL, 32'h00000370, 1'h0);
		acc(1'h0, 2'h3, 1'h1, 13'h5, 18'h111);
		look(1'h0, 18'h0c3);
		acc(1'h0, 2'h0, 1'h1, 13'h5, 18'h0ff);
		acc(1'h0, 2'h3, 1'h0, 13'h5, 18'h0);
		look(1'h0, 18'h111);
		wr(`OFS_CTRL, 32'h00000364, 1'h0);
		acc(1'h0, 2'h3, 1'h1, 13'h5, 18'h0aa);
		acc(1'h0, 2'h3, 1'h0, 13'h5, 18'h0);
		look(1'h0, 18'h111);
		acc(1'h0, 2'h3, 1'h0, 13'h5, 18'h0);
		look(1'h0, 18'h0aa);
		$display("test ram done");
	endtask

	// Nine-bit word on port A read back bit by bit on a one-bit port B.
	task automatic t_width;
		wr(`OFS_CTRL, 32'h00000b00, 1'h0);
		acc(1'h0, 2'h3, 1'h1, 13'h0, 18'h1a5);
		for (int i = 0; i < 9; i++) begin
			acc(1'h1, 2'h3, 1'h0, 13'(i), 18'h0);
			look(1'h1, (18'h1a5 >> i) & 18'h1);
		end
		$display("test width done");
	endtask

	// Preloaded word survives a port write in read-only mode.
	task automatic t_rom;
		wr(`OFS_PRELOAD, 32'h002ac007, 1'h0);
		wr(`OFS_CTRL, 32'h00000361, 1'h0);
		acc(1'h0, 2'h3, 1'h1, 13'h7, 18'h1ff);
		acc(1'h0, 2'h3, 1'h0, 13'h7, 18'h0);
		look(1'h0, 18'h0ab);
		$display("test rom done");
	endtask

	// Thresholds, fill past full, pops, rewind and global reset.
	task automatic t_fifo;
		wr(`OFS_CTRL, 32'h00001b00, 1'h0);
		wr(`OFS_FULL_THR, 32'h4, 1'h0);
		wr(`OFS_NFULL_THR, 32'h3, 1'h0);
		wr(`OFS_NEMPTY_THR, 32'h1, 1'h0);
		wr(`OFS_FULL_THR, 32'h0, 1'h1);
		wr(`OFS_NFULL_THR, 32'h4, 1'h1);
		rd(`OFS_FULL_THR, 32'h4);
		rst_pulse(1'h0);
		acc(1'h0, 2'h2, 1'h1, 13'h0, 18'h0ff);
		tick();
		chk(32'(fifo_flags), 32'h3);
		for (int i = 0; i < 5; i++) acc(1'h0, 2'h3, 1'h1, 13'h0, 18'h100 + 18'(i));
		tick();
		chk(32'(fifo_flags), 32'hc);
		rd(`OFS_STATUS, 32'h00030004);
		for (int i = 0; i < 2; i++) begin
			acc(1'h1, 2'h3, 1'h1, 13'h0, 18'h0);
			look(1'h1, 18'h100 + 18'(i));
		end
		chk(32'(fifo_flags), 32'h0);
		rst_pulse(1'h1);
		for (int i = 0; i < 4; i++) begin
			acc(1'h1, 2'h3, 1'h1, 13'h0, 18'h0);
			look(1'h1, 18'h100 + 18'(i));
		end
		chk(32'(fifo_flags), 32'h3);
		acc(1'h1, 2'h3, 1'h1, 13'h0, 18'h0);
		look(1'h1, 18'h103);
		acc(1'h0, 2'h3, 1'h1, 13'h0, 18'h001);
		rst_pulse(1'h0);
		tick();
		chk(32'(fifo_flags), 32'h3);
		rd(`OFS_STATUS, 32'h0000c000);
		$display("test fifo done");
	endtask

	// Local port clear and chip-wide clear of the output latches.
	task automatic t_clr;
		wr(`OFS_CTRL, 32'h00000b60, 1'h0);
		acc(1'h0, 2'h3, 1'h1, 13'h2, 18'h1aa);
		acc(1'h1, 2'h3, 1'h0, 13'h2, 18'h0);
		look(1'h1, 18'h1aa);
		acc(1'h0, 2'h3, 1'h0, 13'h2, 18'h0);
		fab.go(1'h0, 2'h0, 1'h0, 1'h1, 13'h0, 18'h0);
		look(1'h0, 18'h0);
		chk(32'(port_b_rdata), 32'h1aa);
		acc(1'h0, 2'h3, 1'h0, 13'h2, 18'h0);
		look(1'h0, 18'h1aa);
		@(posedge pclk);
		global_set_reset_n <= 1'h0;
		#1;
		chk(32'(port_a_rdata), 32'h0);
		chk(32'(port_b_rdata), 32'h0);
		@(posedge pclk);
		global_set_reset_n <= 1'h1;
		$display("test clear done");
	endtask

	// Main sequence.
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		global_set_reset_n = 1'h1;
		fifo_global_reset = 1'h0;
		rd_ptr_rewind = 1'h0;
		repeat (16) @(posedge pclk);
		presetn <= 1'h1;
		t_regs();
		t_ram();
		t_width();
		t_rom();
		t_fifo();
		t_clr();
		stop_test();
	end

	// Cuts a hang short.
	initial begin
		#100000;
		n_mismatch++;
		stop_test();
	end
endmodule
